//--- hdl/tpg_pkg.sv
// Types shared by the GPIO port modules
package tpg_pkg;

	typedef logic [7:0] tpg_byte_t;

	// Which register of a port an access selects
	typedef enum logic [2:0]
	{
		TPG_SEL_NONE = 3'b000,
		TPG_SEL_MODE = 3'b001,
		TPG_SEL_DIR = 3'b010,
		TPG_SEL_LATCH = 3'b011,
		TPG_SEL_LEVEL = 3'b100
	} tpg_sel_t;

	// State of one port
	typedef struct packed
	{
		tpg_byte_t mode;
		tpg_byte_t dir;
		tpg_byte_t latch;
		logic pulls_on;
		tpg_byte_t sync1;
		tpg_byte_t sync2;
	} tpg_port_state_t;

	// State of the top: read data and registered pin drive
	typedef struct packed
	{
		tpg_byte_t rdata;
		logic rvalid;
		logic [2:0][7:0] drive;
		logic [2:0][7:0] enable;
	} tpg_top_state_t;

endpackage

//--- hdl/tpg_port.sv
// Register set and pin synchroniser of one eight-pin port
`timescale 1ns/100ps
`include "tpg_regs.svh"
module tpg_port
(
	input wire logic clk_in, // System clock
	input wire logic reset_n_in, // Synchronous reset, active low
	tpg_port_if.regs bus, // Register access from the top
	input wire tpg_pkg::tpg_byte_t pin_in // Raw pin levels
);
	import tpg_pkg::*;

	tpg_port_state_t st_r;
	tpg_port_state_t st_nxt;

	// Next state: register writes, pull flag, two-stage synchroniser
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.sync1 = pin_in;
		st_nxt.sync2 = st_r.sync1;
		if (bus.wr_mode)
		begin
			st_nxt.mode = bus.wdata;
			st_nxt.pulls_on = 1'b0;
		end
		if (bus.wr_dir)
		begin
			st_nxt.dir = bus.wdata;
		end
		if (bus.wr_latch)
		begin
			st_nxt.latch = bus.wdata;
		end
	end

	// Reset leaves pins as I/O inputs with pulls on
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			st_r.mode <= `TPG_MODE_RESET;
			st_r.dir <= `TPG_DIR_RESET;
			st_r.latch <= `TPG_LATCH_RESET;
			st_r.pulls_on <= 1'b1;
			st_r.sync1 <= 8'h00;
			st_r.sync2 <= 8'h00;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// Values seen by the top
	assign bus.mode = st_r.mode;
	assign bus.dir = st_r.dir;
	assign bus.latch = st_r.latch;
	assign bus.level = st_r.sync2;
	assign bus.pulls_on = st_r.pulls_on;

endmodule

//--- hdl/tpg_port_if.sv
// Carrier between the bus decode in the top and one port register set
`timescale 1ns/100ps
interface tpg_port_if;
	import tpg_pkg::*;

	logic wr_mode;
	logic wr_dir;
	logic wr_latch;
	tpg_byte_t wdata;
	tpg_byte_t mode;
	tpg_byte_t dir;
	tpg_byte_t latch;
	tpg_byte_t level;
	logic pulls_on;

	modport ctrl
	(
		output wr_mode, wr_dir, wr_latch, wdata,
		input mode, dir, latch, level, pulls_on
	);

	modport regs
	(
		input wr_mode, wr_dir, wr_latch, wdata,
		output mode, dir, latch, level, pulls_on
	);

endinterface

//--- hdl/tpg_regs.svh
// Register offsets, reset values, pin routing masks for the GPIO ports
`ifndef TPG_REGS_SVH
`define TPG_REGS_SVH

// Mode select registers, one per port
`define TPG_MODE1_ADDR 16'hF820
`define TPG_MODE2_ADDR 16'hF822
`define TPG_MODE3_ADDR 16'hF824

// Pin level, output latch and direction registers
`define TPG_LEVEL1_ADDR 16'hF860
`define TPG_LATCH1_ADDR 16'hF862
`define TPG_DIR1_ADDR 16'hF864
`define TPG_LEVEL2_ADDR 16'hF868
`define TPG_LATCH2_ADDR 16'hF86A
`define TPG_DIR2_ADDR 16'hF86C
`define TPG_LEVEL3_ADDR 16'hF870
`define TPG_LATCH3_ADDR 16'hF872
`define TPG_DIR3_ADDR 16'hF874

// Reset values
`define TPG_MODE_RESET 8'h00
`define TPG_DIR_RESET 8'hFF
`define TPG_LATCH_RESET 8'hFF

// Pins whose peripheral signal is an output of the device
`define TPG_P1_PERIPH_OUT 8'hA6
`define TPG_P2_PERIPH_OUT 8'h5F
`define TPG_P3_PERIPH_OUT 8'h43

// Pins with a weak pull-up after reset; all others pull down
`define TPG_P1_PULL_UP 8'h3F
`define TPG_P2_PULL_UP 8'h9F
`define TPG_P3_PULL_UP 8'h00

// Value of the bus read data when no register answers
`define TPG_UNMAPPED_DATA 8'h00

`endif

//--- hdl/tpg_top.sv
// Three multiplexed eight-pin GPIO ports with peripheral pin routing
// Notes on behaviour
// - Three identical eight-pin ports, each with mode, direction, latch, level
// - Mode bit one hands pin to peripheral; zero gives software control
// - Peripheral mode follows peripheral direction; direction and latch ignored
// - I/O mode, direction one, latch one: pin floats as an input
// - I/O mode, direction one: latch zero drives low, one floats
// - I/O mode, direction zero: latch value driven both high and low
// - Latch reads return stored value, never the pin level
// - Level register reads pins in any mode; writes are ignored
// - Mode, direction, latch read/write; level read-only; all I/O mapped
// - Reset makes every pin an I/O input; direction and latch all ones
// - Weak pulls on from reset, up or down per pin
// - Any mode register write turns that port's pulls off until reset
// - Port 1 carries serial modem and bus lock/hold; port 2 selects, serial
// - Port 3 carries timers, four interrupts, power-down and serial clock
`timescale 1ns/100ps
`include "tpg_regs.svh"
module tpg_top
(
	input wire logic clk_in, // System clock, 50 MHz
	input wire logic reset_n_in, // Synchronous reset, active low
	// Processor I/O space access
	input wire logic [15:0] io_addr_in, // I/O byte address
	input wire logic io_wr_in, // Write strobe, one cycle
	input wire logic io_rd_in, // Read strobe, one cycle
	input wire tpg_pkg::tpg_byte_t io_wdata_in, // Write data
	output tpg_pkg::tpg_byte_t io_rdata_out, // Read data, registered
	output logic io_rvalid_out, // Read data valid pulse
	// Pins, five signals per pin
	input wire tpg_pkg::tpg_byte_t port1_pin_in, // Port 1 pin level
	input wire tpg_pkg::tpg_byte_t port2_pin_in, // Port 2 pin level
	input wire tpg_pkg::tpg_byte_t port3_pin_in, // Port 3 pin level
	output tpg_pkg::tpg_byte_t port1_pin_out, // Port 1 drive value
	output tpg_pkg::tpg_byte_t port2_pin_out, // Port 2 drive value
	output tpg_pkg::tpg_byte_t port3_pin_out, // Port 3 drive value
	output tpg_pkg::tpg_byte_t port1_pin_oe_out, // Port 1 drive enable
	output tpg_pkg::tpg_byte_t port2_pin_oe_out, // Port 2 drive enable
	output tpg_pkg::tpg_byte_t port3_pin_oe_out, // Port 3 drive enable
	output tpg_pkg::tpg_byte_t port1_weak_pull_high_out, // Weak pull-ups
	output tpg_pkg::tpg_byte_t port2_weak_pull_high_out, // Weak pull-ups
	output tpg_pkg::tpg_byte_t port3_weak_pull_high_out, // Weak pull-ups
	output tpg_pkg::tpg_byte_t port1_weak_pull_low_out, // Weak pull-downs
	output tpg_pkg::tpg_byte_t port2_weak_pull_low_out, // Weak pull-downs
	output tpg_pkg::tpg_byte_t port3_weak_pull_low_out, // Weak pull-downs
	// Peripheral outputs bound for pins
	input wire logic serial0_request_to_send_n_in, // Port 1 bit 1
	input wire logic serial0_terminal_ready_n_in, // Port 1 bit 2
	input wire logic bus_lock_n_in, // Port 1 bit 5
	input wire logic bus_hold_ack_in, // Port 1 bit 7
	input wire logic [4:0] chip_select_n_in, // Port 2 bits 4..0
	input wire logic serial0_transmit_line_in, // Port 2 bit 6
	input wire logic timer0_output_in, // Port 3 bit 0
	input wire logic timer1_output_in, // Port 3 bit 1
	input wire logic power_down_indicator_in, // Port 3 bit 6
	// Pin levels delivered to peripheral inputs
	output logic serial0_carrier_detect_n_out, // Port 1 bit 0
	output logic serial0_set_ready_n_out, // Port 1 bit 3
	output logic serial0_ring_indicator_n_out, // Port 1 bit 4
	output logic bus_hold_req_out, // Port 1 bit 6
	output logic serial0_receive_line_out, // Port 2 bit 5
	output logic serial0_clear_to_send_n_out, // Port 2 bit 7
	output logic [3:0] irq_input_out, // Port 3 bits 5..2
	output logic serial_comm_clock_out // Port 3 bit 7
);
	import tpg_pkg::*;

	localparam int NPORTS = 3;

	// Per-port routing constants, indexed by port number minus one
	localparam logic [NPORTS-1:0][7:0] PERIPH_OUT =
		{`TPG_P3_PERIPH_OUT, `TPG_P2_PERIPH_OUT, `TPG_P1_PERIPH_OUT};
	localparam logic [NPORTS-1:0][7:0] PULL_UP =
		{`TPG_P3_PULL_UP, `TPG_P2_PULL_UP, `TPG_P1_PULL_UP};

	tpg_top_state_t st_r;
	tpg_top_state_t st_nxt;

	tpg_port_if port_bus [NPORTS] ();

	logic [NPORTS-1:0][7:0] raw_pin;
	logic [NPORTS-1:0][7:0] periph_data;
	logic [NPORTS-1:0][7:0] periph_seen;
	logic [NPORTS-1:0][7:0] mode_v;
	logic [NPORTS-1:0][7:0] dir_v;
	logic [NPORTS-1:0][7:0] latch_v;
	logic [NPORTS-1:0][7:0] level_v;
	logic [NPORTS-1:0] pulls_v;
	logic [NPORTS-1:0][7:0] pull_on;
	logic [1:0] acc_port;
	tpg_sel_t acc_sel;

	// Address decode: picks a port and one of its four registers
	always_comb
	begin
		acc_port = 2'd0;
		acc_sel = TPG_SEL_NONE;
		unique case (io_addr_in)
			`TPG_MODE1_ADDR:
			begin
				acc_port = 2'd0;
				acc_sel = TPG_SEL_MODE;
			end
			`TPG_LEVEL1_ADDR:
			begin
				acc_port = 2'd0;
				acc_sel = TPG_SEL_LEVEL;
			end
			`TPG_LATCH1_ADDR:
			begin
				acc_port = 2'd0;
				acc_sel = TPG_SEL_LATCH;
			end
			`TPG_DIR1_ADDR:
			begin
				acc_port = 2'd0;
				acc_sel = TPG_SEL_DIR;
			end
			`TPG_MODE2_ADDR:
			begin
				acc_port = 2'd1;
				acc_sel = TPG_SEL_MODE;
			end
			`TPG_LEVEL2_ADDR:
			begin
				acc_port = 2'd1;
				acc_sel = TPG_SEL_LEVEL;
			end
			`TPG_LATCH2_ADDR:
			begin
				acc_port = 2'd1;
				acc_sel = TPG_SEL_LATCH;
			end
			`TPG_DIR2_ADDR:
			begin
				acc_port = 2'd1;
				acc_sel = TPG_SEL_DIR;
			end
			`TPG_MODE3_ADDR:
			begin
				acc_port = 2'd2;
				acc_sel = TPG_SEL_MODE;
			end
			`TPG_LEVEL3_ADDR:
			begin
				acc_port = 2'd2;
				acc_sel = TPG_SEL_LEVEL;
			end
			`TPG_LATCH3_ADDR:
			begin
				acc_port = 2'd2;
				acc_sel = TPG_SEL_LATCH;
			end
			`TPG_DIR3_ADDR:
			begin
				acc_port = 2'd2;
				acc_sel = TPG_SEL_DIR;
			end
			default: acc_sel = TPG_SEL_NONE; // Unmapped address
		endcase
	end

	// Pins as a packed array, port 1 in slot 0
	assign raw_pin = {port3_pin_in, port2_pin_in, port1_pin_in};

	// Peripheral outputs placed on their pins; input slots stay zero
	assign periph_data[0] = {bus_hold_ack_in, 1'b0, bus_lock_n_in,
		2'b00, serial0_terminal_ready_n_in,
		serial0_request_to_send_n_in, 1'b0};
	assign periph_data[1] = {1'b0, serial0_transmit_line_in, 1'b0,
		chip_select_n_in};
	assign periph_data[2] = {1'b0, power_down_indicator_in, 4'h0,
		timer1_output_in, timer0_output_in};

	// One register set per port; the top never reads a raw pin itself
	generate
		for (genvar p = 0; p < NPORTS; p++)
		begin : g_port
			// Write strobes go to the addressed port only
			assign port_bus[p].wr_mode = io_wr_in &&
				acc_port == 2'(p) && acc_sel == TPG_SEL_MODE;
			assign port_bus[p].wr_dir = io_wr_in &&
				acc_port == 2'(p) && acc_sel == TPG_SEL_DIR;
			assign port_bus[p].wr_latch = io_wr_in &&
				acc_port == 2'(p) && acc_sel == TPG_SEL_LATCH;
			assign port_bus[p].wdata = io_wdata_in;
			assign mode_v[p] = port_bus[p].mode;
			assign dir_v[p] = port_bus[p].dir;
			assign latch_v[p] = port_bus[p].latch;
			assign level_v[p] = port_bus[p].level;
			assign pulls_v[p] = port_bus[p].pulls_on;

			tpg_port u_port
			(
				.clk_in(clk_in),
				.reset_n_in(reset_n_in),
				.bus(port_bus[p]),
				.pin_in(raw_pin[p])
			);

			// Peripheral inputs see the synchronised pin in peripheral
			// mode, else their idle level so no false event appears
			assign periph_seen[p] = (mode_v[p] & level_v[p]) |
				(~mode_v[p] & PULL_UP[p]);

			// Pulls stay on while reset is held and until a mode write
			assign pull_on[p] = {8{pulls_v[p] | ~reset_n_in}};
		end
	endgenerate

	// Pin drive per bit; the state is registered below
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.rvalid = io_rd_in;
		for (int p = 0; p < NPORTS; p++)
		begin
			for (int b = 0; b < 8; b++)
			begin
				if (mode_v[p][b])
				begin
					st_nxt.drive[p][b] = periph_data[p][b];
					st_nxt.enable[p][b] = PERIPH_OUT[p][b];
				end
				else if (dir_v[p][b])
				begin
					st_nxt.drive[p][b] = 1'b0;
					st_nxt.enable[p][b] = ~latch_v[p][b];
				end
				else
				begin
					st_nxt.drive[p][b] = latch_v[p][b];
					st_nxt.enable[p][b] = 1'b1;
				end
			end
		end
		// Read data is captured on the strobe edge and held until next read
		if (io_rd_in)
		begin
			unique case (acc_sel)
				TPG_SEL_MODE: st_nxt.rdata = mode_v[acc_port];
				TPG_SEL_DIR: st_nxt.rdata = dir_v[acc_port];
				TPG_SEL_LATCH: st_nxt.rdata = latch_v[acc_port];
				TPG_SEL_LEVEL: st_nxt.rdata = level_v[acc_port];
				default: st_nxt.rdata = `TPG_UNMAPPED_DATA;
			endcase
		end
	end

	// State register
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			st_r.rdata <= `TPG_UNMAPPED_DATA;
			st_r.rvalid <= 1'b0;
			st_r.drive <= '0;
			st_r.enable <= '0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// Bus answer
	assign io_rdata_out = st_r.rdata;
	assign io_rvalid_out = st_r.rvalid;

	// Pin drive; enables drop at once while reset is low, so the pins
	// let go without waiting for a clock edge
	assign port1_pin_out = st_r.drive[0];
	assign port2_pin_out = st_r.drive[1];
	assign port3_pin_out = st_r.drive[2];
	assign port1_pin_oe_out = st_r.enable[0] & {8{reset_n_in}};
	assign port2_pin_oe_out = st_r.enable[1] & {8{reset_n_in}};
	assign port3_pin_oe_out = st_r.enable[2] & {8{reset_n_in}};

	// Weak pulls, direction fixed per pin
	assign port1_weak_pull_high_out = pull_on[0] & PULL_UP[0];
	assign port2_weak_pull_high_out = pull_on[1] & PULL_UP[1];
	assign port3_weak_pull_high_out = pull_on[2] & PULL_UP[2];
	assign port1_weak_pull_low_out = pull_on[0] & ~PULL_UP[0];
	assign port2_weak_pull_low_out = pull_on[1] & ~PULL_UP[1];
	assign port3_weak_pull_low_out = pull_on[2] & ~PULL_UP[2];

	// Port 1 inputs: serial modem status and bus hold request
	assign serial0_carrier_detect_n_out = periph_seen[0][0];
	assign serial0_set_ready_n_out = periph_seen[0][3];
	assign serial0_ring_indicator_n_out = periph_seen[0][4];
	assign bus_hold_req_out = periph_seen[0][6];

	// Port 2 inputs: serial receive and clear-to-send
	assign serial0_receive_line_out = periph_seen[1][5];
	assign serial0_clear_to_send_n_out = periph_seen[1][7];

	// Port 3 inputs: interrupt requests and serial clock
	assign irq_input_out = periph_seen[2][5:2];
	assign serial_comm_clock_out = periph_seen[2][7];

endmodule

//--- tb/tpg_pin_model.sv
// Board side of one port: wire resolution, pulls and board drivers
`timescale 1ns/100ps
module tpg_pin_model
(
	input wire logic clk_in, // Clock for the floating pattern
	input wire logic [7:0] dut_val_in, // Device drive value
	input wire logic [7:0] dut_oe_in, // Device drive enable
	input wire logic [7:0] pull_high_in, // Weak pull-ups
	input wire logic [7:0] pull_low_in, // Weak pull-downs
	input wire logic [7:0] ext_oe_in, // Board drive enable
	input wire logic [7:0] ext_val_in, // Board drive value
	output logic [7:0] level_out // Resolved wire level
);
	logic [7:0] flt_r = 8'h55;
	// A wire nobody holds keeps changing, so no stale level passes
	always @(posedge clk_in)
		flt_r <= ~flt_r;
	// Device drive wins; board drives only released pins
	always_comb
		for (int b = 0; b < 8; b++)
			level_out[b] = dut_oe_in[b] ? dut_val_in[b] :
				ext_oe_in[b] ? ext_val_in[b] : pull_high_in[b] ? 1'b1 :
				pull_low_in[b] ? 1'b0 : flt_r[b];
endmodule

//--- tb/tpg_top_asserts.sv
// Concurrent checks on the GPIO register bus and pin controls
`timescale 1ns/100ps
module tpg_top_asserts
(
	input wire logic clk_in, // Clock
	input wire logic reset_n_in, // Reset, active low
	input wire logic [15:0] io_addr_in, // Address
	input wire logic io_wr_in, // Write strobe
	input wire logic io_rd_in, // Read strobe
	input wire tpg_pkg::tpg_byte_t io_wdata_in, // Write data
	input wire tpg_pkg::tpg_byte_t io_rdata_out, // Read data
	input wire logic io_rvalid_out, // Read valid
	input wire tpg_pkg::tpg_byte_t port1_weak_pull_high_out, // Pull-ups
	input wire tpg_pkg::tpg_byte_t port1_weak_pull_low_out, // Pull-downs
	input wire tpg_pkg::tpg_byte_t port2_weak_pull_high_out, // Pull-ups
	input wire tpg_pkg::tpg_byte_t port2_weak_pull_low_out, // Pull-downs
	input wire tpg_pkg::tpg_byte_t port3_pin_oe_out // Port 3 enables
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	// Bus answer timing and data hold
	a_read_answer: assert property (io_rd_in |=> io_rvalid_out)
		else $error("no read valid one cycle after strobe");
	a_rdata_holds: assert property (!io_rd_in |=> $stable(io_rdata_out))
		else $error("read data moved without a read");
	a_unmapped_zero: assert property (io_rd_in && io_addr_in == 16'hF866
		|=> io_rdata_out == 8'h00) else $error("unmapped read not zero");
	// Pulls: fixed map until a mode write, then off for good
	a_mode_pulls_off: assert property (io_wr_in && io_addr_in == 16'hF820
		|=> (port1_weak_pull_high_out | port1_weak_pull_low_out) == 8'h00)
		else $error("pulls still on after mode write");
	a_pulls_stay_off: assert property ((port2_weak_pull_high_out
		| port2_weak_pull_low_out) == 8'h00 |=> (port2_weak_pull_high_out
		| port2_weak_pull_low_out) == 8'h00) else $error("pulls came back");
	a_pull_map_one: assert property ((port1_weak_pull_high_out == 8'h3F
		&& port1_weak_pull_low_out == 8'hC0) || (port1_weak_pull_high_out
		| port1_weak_pull_low_out) == 8'h00) else $error("port 1 pull map");
	a_pull_map_two: assert property (port2_weak_pull_high_out == 8'h9F
		? port2_weak_pull_low_out == 8'h60 : (port2_weak_pull_high_out
		| port2_weak_pull_low_out) == 8'h00) else $error("port 2 pull map");
	// Full peripheral mode drives only peripheral output pins
	a_periph_oe: assert property ((io_wr_in && io_addr_in == 16'hF824
		&& io_wdata_in == 8'hFF) ##1 !(io_wr_in && io_addr_in == 16'hF824)
		|=> port3_pin_oe_out == 8'h43) else $error("port 3 enables wrong");
endmodule

//--- tb/tpg_top_tb.sv
// Self-checking bench for the three-port GPIO block
`timescale 1ns/100ps
module tpg_top_tb;
	import tpg_pkg::*;
	logic clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic [15:0] io_addr_in = 16'h0000;
	logic io_wr_in = 1'b0;
	logic io_rd_in = 1'b0;
	tpg_byte_t io_wdata_in = 8'h00;
	tpg_byte_t io_rdata_out;
	logic io_rvalid_out;
	tpg_byte_t pin[3], pout[3], poe[3], pu[3], pd[3], ext[3], eoe[3];
	tpg_byte_t mode[3], dir[3], lat[3];
	tpg_byte_t pum[3] = '{8'h3F, 8'h9F, 8'h00};
	tpg_byte_t pom[3] = '{8'hA6, 8'h5F, 8'h43};
	logic pon[3];
	logic [12:0] per = 13'h0000;
	logic [10:0] fb;
	int err_count = 0;
	int check_count = 0;
	always #10 clk_in = ~clk_in;
	tpg_top dut
	(
		.clk_in(clk_in), .reset_n_in(reset_n_in), .io_addr_in(io_addr_in),
		.io_wr_in(io_wr_in), .io_rd_in(io_rd_in), .io_wdata_in(io_wdata_in),
		.io_rdata_out(io_rdata_out), .io_rvalid_out(io_rvalid_out),
		.port1_pin_in(pin[0]), .port2_pin_in(pin[1]), .port3_pin_in(pin[2]),
		.port1_pin_out(pout[0]), .port2_pin_out(pout[1]),
		.port3_pin_out(pout[2]), .port1_pin_oe_out(poe[0]),
		.port2_pin_oe_out(poe[1]), .port3_pin_oe_out(poe[2]),
		.port1_weak_pull_high_out(pu[0]), .port2_weak_pull_high_out(pu[1]),
		.port3_weak_pull_high_out(pu[2]), .port1_weak_pull_low_out(pd[0]),
		.port2_weak_pull_low_out(pd[1]), .port3_weak_pull_low_out(pd[2]),
		.serial0_request_to_send_n_in(per[0]),
		.serial0_terminal_ready_n_in(per[1]), .bus_lock_n_in(per[2]),
		.bus_hold_ack_in(per[3]), .chip_select_n_in(per[8:4]),
		.serial0_transmit_line_in(per[9]), .timer0_output_in(per[10]),
		.timer1_output_in(per[11]), .power_down_indicator_in(per[12]),
		.serial0_carrier_detect_n_out(fb[0]), .serial0_set_ready_n_out(fb[1]),
		.serial0_ring_indicator_n_out(fb[2]), .bus_hold_req_out(fb[3]),
		.serial0_receive_line_out(fb[4]), .serial0_clear_to_send_n_out(fb[5]),
		.irq_input_out(fb[9:6]), .serial_comm_clock_out(fb[10])
	);
	// Board model on each port
	for (genvar p = 0; p < 3; p++)
	begin : g_pin
		tpg_pin_model u_pin
		(
			.clk_in(clk_in), .dut_val_in(pout[p]), .dut_oe_in(poe[p]),
			.pull_high_in(pu[p]), .pull_low_in(pd[p]), .ext_oe_in(eoe[p]),
			.ext_val_in(ext[p]), .level_out(pin[p])
		);
	end
	task automatic finish_test();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
		check_count++;
		if (g !== e)
		begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Peripheral output signals as they should land on each port
	function automatic tpg_byte_t pv(int p);
		if (p == 0)
			return {per[3], 1'h0, per[2], 2'h0, per[1:0], 1'h0};
		if (p == 1)
			return {1'h0, per[9], 1'h0, per[8:4]};
		return {1'h0, per[12], 4'h0, per[11:10]};
	endfunction
	function automatic tpg_byte_t xoe(int p);
		return ~mode[p] & (~dir[p] | ~lat[p]) | mode[p] & pom[p];
	endfunction
	function automatic tpg_byte_t xlvl(int p);
		return xoe(p) & (mode[p] & pv(p) | ~mode[p] & lat[p])
			| ~xoe(p) & ext[p];
	endfunction
	task automatic mdl_reset();
		for (int p = 0; p < 3; p++)
		begin
			mode[p] = 8'h00;
			dir[p] = 8'hFF;
			lat[p] = 8'hFF;
			pon[p] = 1'b1;
		end
	endtask
	task automatic wr(logic [15:0] a, tpg_byte_t d);
		@(negedge clk_in);
		io_addr_in = a;
		io_wdata_in = d;
		io_wr_in = 1'b1;
		@(negedge clk_in);
		io_wr_in = 1'b0;
		for (int p = 0; p < 3; p++)
		begin
			pon[p] = (a == 16'hF820 + 16'(2 * p)) ? 1'b0 : pon[p];
			mode[p] = (a == 16'hF820 + 16'(2 * p)) ? d : mode[p];
			lat[p] = (a == 16'hF862 + 16'(8 * p)) ? d : lat[p];
			dir[p] = (a == 16'hF864 + 16'(8 * p)) ? d : dir[p];
		end
	endtask
	task automatic rd(logic [15:0] a, tpg_byte_t e);
		@(negedge clk_in);
		io_addr_in = a;
		io_rd_in = 1'b1;
		@(negedge clk_in);
		io_rd_in = 1'b0;
		chk("rvalid", 16'h0001, {15'h0000, io_rvalid_out});
		chk("rdata", e, io_rdata_out);
	endtask
	// Board releases driven pins, waits out the synchroniser, checks all
	task automatic settle();
		tpg_byte_t v[3];
		for (int p = 0; p < 3; p++)
			eoe[p] = ~xoe(p);
		repeat (4) @(negedge clk_in);
		for (int p = 0; p < 3; p++)
		begin
			chk("oe", xoe(p), poe[p]);
			chk("drive", xlvl(p) & xoe(p), pout[p] & xoe(p));
			chk("pull_up", pon[p] ? pum[p] : 8'h00, pu[p]);
			chk("pull_down", pon[p] ? 8'(~pum[p]) : 8'h00, pd[p]);
			v[p] = mode[p] & xlvl(p) | ~mode[p] & pum[p];
			rd(16'hF860 + 16'(8 * p), xlvl(p));
		end
		chk("periph_in", {5'h00, v[2][7], v[2][5:2], v[1][7], v[1][5],
			v[0][6], v[0][4:3], v[0][0]}, {5'h00, fb});
	endtask
	// Hang guard
	initial
	begin
		#100000;
		err_count++;
		finish_test();
	end
	initial
	begin
		void'($urandom(32'h868CA64C));
		for (int p = 0; p < 3; p++)
			ext[p] = 8'($urandom);
		mdl_reset();
		repeat (8) @(negedge clk_in);
		reset_n_in = 1'b1;
		settle();
		for (int p = 0; p < 3; p++)
		begin
			rd(16'hF820 + 16'(2 * p), 8'h00);
			rd(16'hF862 + 16'(8 * p), 8'hFF);
			rd(16'hF864 + 16'(8 * p), 8'hFF);
		end
		rd(16'hF866, 8'h00);
		// Random mixed setups, written latch, direction, then mode
		repeat (5)
			for (int p = 0; p < 3; p++)
			begin
				wr(16'hF862 + 16'(8 * p), 8'($urandom));
				wr(16'hF864 + 16'(8 * p), 8'($urandom));
				wr(16'hF860 + 16'(8 * p), 8'($urandom));
				wr(16'hF820 + 16'(2 * p), 8'($urandom));
				per = 13'($urandom);
				ext[p] = 8'($urandom);
				settle();
				rd(16'hF862 + 16'(8 * p), lat[p]);
				wr(16'hF862 + 16'(8 * p), lat[p] ^ 8'h81);
				rd(16'hF864 + 16'(8 * p), dir[p]);
				rd(16'hF820 + 16'(2 * p), mode[p]);
				settle();
			end
		// Every pin handed to its peripheral
		for (int p = 0; p < 3; p++)
			wr(16'hF820 + 16'(2 * p), 8'hFF);
		repeat (3)
		begin
			per = 13'($urandom);
			settle();
		end
		// Reset in mid-run releases pins at once
		@(negedge clk_in);
		reset_n_in = 1'b0;
		#1;
		for (int p = 0; p < 3; p++)
		begin
			chk("oe_reset", 8'h00, poe[p]);
			chk("pull_reset", pum[p], pu[p]);
		end
		repeat (3) @(negedge clk_in);
		reset_n_in = 1'b1;
		mdl_reset();
		settle();
		rd(16'hF874, 8'hFF);
		finish_test();
	end
endmodule
bind tpg_top tpg_top_asserts u_chk
(
	.clk_in(clk_in), .reset_n_in(reset_n_in), .io_addr_in(io_addr_in),
	.io_wr_in(io_wr_in), .io_rd_in(io_rd_in), .io_wdata_in(io_wdata_in),
	.io_rdata_out(io_rdata_out), .io_rvalid_out(io_rvalid_out),
	.port1_weak_pull_high_out(port1_weak_pull_high_out),
	.port1_weak_pull_low_out(port1_weak_pull_low_out),
	.port2_weak_pull_high_out(port2_weak_pull_high_out),
	.port2_weak_pull_low_out(port2_weak_pull_low_out),
	.port3_pin_oe_out(port3_pin_oe_out)
);
